// ---- pcicf_pkg.sv ----
// Constants for the function-one configuration header.
package pcicf_pkg;

    // ------------------------------------------------------------
    // Header byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_CMD_STAT = 8'h04;
    localparam logic [7:0] OFS_REV_CLASS = 8'h08;
    localparam logic [7:0] OFS_HDR_LAT = 8'h0c;
    localparam logic [7:0] OFS_MEM_BASE = 8'h10;
    localparam logic [7:0] OFS_BOARD_ID = 8'h20;
    localparam logic [7:0] OFS_INT_INFO = 8'h3c;

    // ------------------------------------------------------------
    // Command bit positions
    // ------------------------------------------------------------
    localparam int CMD_MEM_BIT = 1;
    localparam int CMD_MASTER_BIT = 2;
    localparam int CMD_PARITY_BIT = 6;
    localparam int CMD_SERR_BIT = 8;
    localparam logic [15:0] CMD_IMPL_MASK = 16'h0146;

    // ------------------------------------------------------------
    // Status bit positions and fixed fields
    // ------------------------------------------------------------
    localparam int ST_PAR_DET_BIT = 31;
    localparam int ST_SERR_SIG_BIT = 30;
    localparam int ST_MST_ABORT_BIT = 29;
    localparam int ST_TGT_ABORT_RX_BIT = 28;
    localparam int ST_TGT_ABORT_TX_BIT = 27;
    localparam int ST_DATA_PAR_BIT = 24;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic [0:0] FAST_B2B_CAPABLE = 1'h1;

    // ------------------------------------------------------------
    // Fixed field values and reset values
    // ------------------------------------------------------------
    localparam logic [23:0] CLASS_CODE = 24'h048000;
    localparam logic [7:0] HEADER_KIND = 8'h80;
    localparam logic [7:0] LAT_TIMER_RESET = 8'h00;
    localparam logic [11:0] MEM_USAGE = 12'h008;
    localparam int MEM_WINDOW_BITS = 12;
    localparam logic [7:0] MAX_LATENCY = 8'hff;
    localparam logic [7:0] MIN_GRANT = 8'h04;
    localparam logic [7:0] INT_PIN_A = 8'h01;
    localparam logic [7:0] INT_LINE_RESET = 8'h00;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [2:0] FUNCTION_ONE = 3'h1;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;

endpackage : pcicf_pkg

// ---- pcicf_lat_if.sv ----
// Signals between the header bank and its latency timer.
interface pcicf_lat_if;
    logic [7:0] load_value;
    logic burst_active;
    logic gnt_held;
    logic expired;
    logic end_burst;

    modport bank (output load_value, burst_active, gnt_held, input expired, end_burst);
    modport timer (input load_value, burst_active, gnt_held, output expired, end_burst);
endinterface : pcicf_lat_if

// ---- pcicf_lat_timer.sv ----
// Master latency timer counting clocks of a burst.
module pcicf_lat_timer
    import pcicf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bank side
    pcicf_lat_if.timer lat
);

    typedef enum logic [2:0]
    {
        LT_IDLE = 3'b001,
        LT_COUNT = 3'b010,
        LT_EXPIRED = 3'b100
    } pcicf_lat_state_t;

    pcicf_lat_state_t state_q;
    logic [7:0] count_q;

    wire count_done = (count_q == 8'h00);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= LT_IDLE;
            count_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                LT_IDLE:
                begin
                    count_q <= lat.load_value;
                    if (lat.burst_active)
                        state_q <= LT_COUNT;
                end
                LT_COUNT:
                begin
                    if (!lat.burst_active)
                        state_q <= LT_IDLE;
                    else if (count_done)
                        state_q <= LT_EXPIRED;
                    else
                        count_q <= count_q - 8'h01;
                end
                LT_EXPIRED:
                begin
                    if (!lat.burst_active)
                        state_q <= LT_IDLE;
                end
                default:
                    state_q <= LT_IDLE;
            endcase
        end
    end

    // Once expired, the burst ends as soon as the grant is taken away.
    assign lat.expired = (state_q == LT_EXPIRED); // RL16
    assign lat.end_burst = lat.expired && !lat.gnt_held; // RL16

endmodule : pcicf_lat_timer

// ---- pcicf_header.sv ----
// Configuration header bank of the second function of a capture device.
//
// How it works
// (RL1) Command zero: only configuration cycles answered
// (RL2) Undefined command bits read zero
// (RL3) Bit 31 set on any parity error; tgt_write_data_parity_err is ignored
// (RL4) Bit 30 set when SERR driven
// (RL5) Bits 29/28 set on master/target abort
// (RL6) Address parity: target abort, set bit 27
// (RL7) Devsel field reads 01, medium timing
// (RL8) Bit 24 set on PERR, if enabled
// (RL9) Bit 23 reads one, fast back-to-back
// (RL10) Command bit 8 gates SERR driver
// (RL11) Command bit 6 enables parity reporting
// (RL12) No mastering unless command bit 2
// (RL13) Memory decode only with command bit 1
// (RL14) Class code 048000, revision read-only
// (RL15) Header kind byte reads 80
// (RL16) Latency timer counts burst, ends after expiry
// (RL17) Base bits 31:12 writable, low reads 008
// (RL18) Maximum latency byte reads ff
// (RL19) Minimum grant byte reads 04
// (RL20) Interrupt pin reads 01, uses INTA
// (RL21) Interrupt line is plain storage
// (RL22) Identity word read-only, writes ignored
// (RL23) Write one clears status, zero keeps
// (RL24) Claim on IDSEL, AD[1:0]=00, function 001
// (RL25) Reserved writes dropped, reads zero
// (RL26) Writable bits reset to zero
module pcicf_header
    import pcicf_pkg::*;
#(
    // Identity defaults below are arbitrary values.
    parameter logic [15:0] VENDOR_CODE = 16'h1234,
    parameter logic [15:0] DEVICE_CODE = 16'h5678,
    parameter logic [7:0] REVISION_CODE = 8'h01,
    parameter logic [15:0] BOARD_VENDOR_CODE = 16'h0abc,
    parameter logic [15:0] BOARD_CODE = 16'h0def,
    parameter int FUNCTION_NUM = 1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration access from the target front end
    input wire logic cfg_req,
    input wire logic cfg_idsel,
    input wire logic [10:0] cfg_ad,
    input wire logic cfg_write,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_claim,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Memory cycle decode
    input wire logic mem_cycle,
    input wire logic [31:0] mem_addr,
    output logic mem_hit,
    output logic [MEM_WINDOW_BITS-3:0] mem_word,
    // Target bus events
    input wire logic addr_parity_err,
    input wire logic data_parity_err,
    input wire logic tgt_write_data_parity_err,
    output logic target_abort,
    output logic devsel_medium,
    output logic fast_b2b_accept,
    // Master side
    input wire logic master_want,
    input wire logic burst_active,
    input wire logic gnt_n,
    input wire logic master_abort_seen,
    input wire logic target_abort_seen,
    input wire logic master_read_parity_err,
    input wire logic master_write_perr_seen,
    output logic master_allowed,
    output logic master_end_burst,
    // Error pins, active low, open drain
    output logic perr_n_out,
    output logic perr_n_oe,
    output logic serr_n_out,
    output logic serr_n_oe,
    // Interrupt pin, active low, open drain
    input wire logic irq_request,
    output logic inta_n_out,
    output logic inta_n_oe,
    // Control seen by the rest of the function
    output logic bus_disconnected,
    output logic [7:0] int_line
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    generate
        if (FUNCTION_NUM < 0 || FUNCTION_NUM > 7)
        begin : g_bad_func
            $error("FUNCTION_NUM must lie in 0 to 7");
        end
    endgenerate

    localparam logic [2:0] FUNC_SEL = 3'(FUNCTION_NUM);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    function automatic logic hit_offset(input logic [7:0] ofs, input logic [7:0] want);
        hit_offset = (ofs == want);
    endfunction : hit_offset

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] command_q;
    logic [4:0] status_q;
    logic [7:0] lat_timer_q;
    logic [31:MEM_WINDOW_BITS] mem_base_q;
    logic [7:0] int_line_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic serr_q;
    logic perr_q;
    logic target_abort_q;

    // ------------------------------------------------------------
    // Configuration cycle decode
    // ------------------------------------------------------------
    wire [7:0] byte_ofs = {cfg_ad[7:2], 2'b00};
    wire type0 = (cfg_ad[1:0] == CFG_TYPE0);
    wire func_hit = (cfg_ad[10:8] == FUNC_SEL);
    wire claim = cfg_req && cfg_idsel && type0 && func_hit; // RL24
    wire wr = claim && cfg_write;
    wire [31:0] wmask = be_mask(cfg_be);
    wire [31:0] wbits = cfg_wdata & wmask;

    wire sel_cmd = hit_offset(byte_ofs, OFS_CMD_STAT);
    wire sel_lat = hit_offset(byte_ofs, OFS_HDR_LAT);
    wire sel_base = hit_offset(byte_ofs, OFS_MEM_BASE);
    wire sel_int = hit_offset(byte_ofs, OFS_INT_INFO);

    wire wr_cmd = wr && sel_cmd;
    wire wr_lat = wr && sel_lat && cfg_be[1];
    wire wr_int = wr && sel_int && cfg_be[0];
    wire wr_base = wr && sel_base;

    // ------------------------------------------------------------
    // Command control
    // ------------------------------------------------------------
    wire mem_en = command_q[CMD_MEM_BIT];
    wire master_en = command_q[CMD_MASTER_BIT];
    wire parity_en = command_q[CMD_PARITY_BIT];
    wire serr_en = command_q[CMD_SERR_BIT];

    // Only implemented bits are stored, others stay zero.
    wire [15:0] cmd_keep = command_q & ~wmask[15:0];
    wire [15:0] cmd_d = (cmd_keep | wbits[15:0]) & CMD_IMPL_MASK; // RL2

    // ------------------------------------------------------------
    // Status events
    // ------------------------------------------------------------
    wire perr_drive = parity_en && (data_parity_err || master_read_parity_err); // RL11
    wire serr_drive = serr_en && addr_parity_err; // RL10
    wire [4:0] st_set;
    assign st_set[4] = addr_parity_err || data_parity_err || master_read_parity_err; // RL3
    assign st_set[3] = serr_drive; // RL4
    assign st_set[2] = master_abort_seen && master_en; // RL5
    assign st_set[1] = target_abort_seen && master_en; // RL5
    assign st_set[0] = parity_en && (master_read_parity_err || master_write_perr_seen); // RL8

    wire tx_abort_set = addr_parity_err && mem_en && mem_cycle; // RL6
    wire [4:0] st_clr_bits = {wbits[ST_PAR_DET_BIT], wbits[ST_SERR_SIG_BIT],
        wbits[ST_MST_ABORT_BIT], wbits[ST_TGT_ABORT_RX_BIT], wbits[ST_DATA_PAR_BIT]};
    wire [4:0] st_clr = wr_cmd ? st_clr_bits : 5'h00;
    // Setting wins over a clear in the same cycle.
    wire [4:0] st_d = (status_q & ~st_clr) | st_set; // RL23

    // Signalled target abort is kept apart since it only fires as target.
    logic sta_q;
    wire sta_clr = wr_cmd && wbits[ST_TGT_ABORT_TX_BIT];
    wire sta_d = (sta_q && !sta_clr) || tx_abort_set; // RL6

    // ------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------
    wire [15:0] status_word = {status_q[4], status_q[3], status_q[2], status_q[1],
        sta_q, DEVSEL_MEDIUM, status_q[0], FAST_B2B_CAPABLE, 7'h00}; // RL7 RL9
    wire [31:0] rd_identity = {DEVICE_CODE, VENDOR_CODE}; // RL22
    wire [31:0] rd_cmd_stat = {status_word, command_q}; // RL2
    wire [31:0] rd_rev_class = {CLASS_CODE, REVISION_CODE}; // RL14
    wire [31:0] rd_hdr_lat = {8'h00, HEADER_KIND, lat_timer_q, 8'h00}; // RL15
    wire [31:0] rd_base = {mem_base_q, MEM_USAGE}; // RL17
    wire [31:0] rd_board = {BOARD_CODE, BOARD_VENDOR_CODE};
    wire [31:0] rd_int = {MAX_LATENCY, MIN_GRANT, INT_PIN_A, int_line_q}; // RL18 RL19 RL20

    logic [31:0] rd_mux;
    always_comb
    begin
        case (byte_ofs)
            OFS_IDENTITY: rd_mux = rd_identity;
            OFS_CMD_STAT: rd_mux = rd_cmd_stat;
            OFS_REV_CLASS: rd_mux = rd_rev_class;
            OFS_HDR_LAT: rd_mux = rd_hdr_lat;
            OFS_MEM_BASE: rd_mux = rd_base;
            OFS_BOARD_ID: rd_mux = rd_board;
            OFS_INT_INFO: rd_mux = rd_int;
            default: rd_mux = '0; // RL25
        endcase
    end

    // ------------------------------------------------------------
    // Writable storage
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            command_q <= CMD_RESET; // RL26
            status_q <= STATUS_RESET;
            sta_q <= 1'b0;
        end
        else
        begin
            if (wr_cmd)
                command_q <= cmd_d; // RL1
            status_q <= st_d;
            sta_q <= sta_d;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lat_timer_q <= LAT_TIMER_RESET; // RL26
            int_line_q <= INT_LINE_RESET;
        end
        else
        begin
            if (wr_lat)
                lat_timer_q <= cfg_wdata[15:8]; // RL16
            if (wr_int)
                int_line_q <= cfg_wdata[7:0]; // RL21
        end
    end

    // Writes to read-only words fall through and are dropped.
    wire [31:MEM_WINDOW_BITS] base_keep = mem_base_q & ~wmask[31:MEM_WINDOW_BITS];
    wire [31:MEM_WINDOW_BITS] base_d = base_keep | wbits[31:MEM_WINDOW_BITS];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mem_base_q <= '0; // RL26
        else if (wr_base)
            mem_base_q <= base_d; // RL17 RL25
    end

    // ------------------------------------------------------------
    // Configuration answer, one cycle after the claim
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ack_q <= claim;
            if (claim && !cfg_write)
                rdata_q <= rd_mux;
        end
    end

    assign cfg_claim = claim; // RL24
    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Memory window decode
    // ------------------------------------------------------------
    wire window_match = (mem_addr[31:MEM_WINDOW_BITS] == mem_base_q);
    assign mem_hit = mem_cycle && mem_en && window_match; // RL13 RL1
    assign mem_word = mem_addr[MEM_WINDOW_BITS-1:2];
    assign devsel_medium = mem_hit; // RL7
    assign fast_b2b_accept = mem_en; // RL9

    // ------------------------------------------------------------
    // Target abort on address parity error
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            target_abort_q <= 1'b0;
        else
            target_abort_q <= tx_abort_set; // RL6
    end

    assign target_abort = target_abort_q;

    // ------------------------------------------------------------
    // Error pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            serr_q <= 1'b0;
            perr_q <= 1'b0;
        end
        else
        begin
            serr_q <= serr_drive; // RL10
            perr_q <= perr_drive; // RL11
        end
    end

    assign serr_n_out = 1'b0;
    assign serr_n_oe = serr_q && serr_en; // RL10
    assign perr_n_out = 1'b0;
    assign perr_n_oe = perr_q && parity_en; // RL11

    // ------------------------------------------------------------
    // Bus mastering and latency timer
    // ------------------------------------------------------------
    pcicf_lat_if lat ();

    assign lat.load_value = lat_timer_q;
    assign lat.burst_active = burst_active && master_en;
    assign lat.gnt_held = !gnt_n;

    pcicf_lat_timer u_lat_timer
    (
        .clk(clk),
        .reset(reset),
        .lat(lat.timer)
    );

    assign master_allowed = master_want && master_en; // RL12 RL1
    assign master_end_burst = lat.end_burst; // RL16

    // ------------------------------------------------------------
    // Interrupt pin and other control
    // ------------------------------------------------------------
    assign inta_n_out = 1'b0;
    assign inta_n_oe = irq_request; // RL20
    assign bus_disconnected = (command_q == CMD_RESET); // RL1
    assign int_line = int_line_q; // RL21

endmodule : pcicf_header

// ---- pcicf_header_sva.sv ----
// Concurrent checks on the ports of the configuration header bank.
module pcicf_header_chk
    import pcicf_pkg::*;
(
    // Clock and reset
    input logic clk,
    input logic reset,
    // Configuration access
    input logic cfg_req,
    input logic cfg_idsel,
    input logic [10:0] cfg_ad,
    input logic cfg_claim,
    input logic cfg_ack,
    // Target side
    input logic mem_cycle,
    input logic [31:0] mem_addr,
    input logic mem_hit,
    input logic [MEM_WINDOW_BITS-3:0] mem_word,
    input logic addr_parity_err,
    input logic data_parity_err,
    input logic target_abort,
    input logic devsel_medium,
    input logic fast_b2b_accept,
    // Master side
    input logic master_want,
    input logic gnt_n,
    input logic master_read_parity_err,
    input logic master_allowed,
    input logic master_end_burst,
    // Pins and control
    input logic perr_n_oe,
    input logic serr_n_oe,
    input logic irq_request,
    input logic inta_n_out,
    input logic inta_n_oe,
    input logic bus_disconnected
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_claim_decode: assert property (cfg_claim == (cfg_req && cfg_idsel &&
        cfg_ad[1:0] == CFG_TYPE0 && cfg_ad[10:8] == FUNCTION_ONE))
        else $error("claim decode");
    chk_ack_after_claim: assert property (cfg_claim |=> cfg_ack)
        else $error("no ack");
    chk_bus_disconnect: assert property (bus_disconnected |->
        !mem_hit && !master_allowed && !fast_b2b_accept)
        else $error("still active");
    chk_mem_decode: assert property (mem_hit |->
        mem_cycle && fast_b2b_accept && mem_word == mem_addr[11:2])
        else $error("bad hit");
    chk_devsel_hit: assert property (devsel_medium == mem_hit)
        else $error("devsel");
    chk_abort_set: assert property (addr_parity_err && mem_cycle && fast_b2b_accept
        |=> target_abort)
        else $error("no abort");
    chk_abort_cause: assert property (target_abort |-> $past(addr_parity_err && mem_cycle))
        else $error("stray abort");
    chk_serr_cause: assert property (serr_n_oe |->
        $past(addr_parity_err) && !$past(bus_disconnected))
        else $error("stray serr");
    chk_perr_cause: assert property (perr_n_oe |->
        $past(data_parity_err || master_read_parity_err) && !$past(bus_disconnected))
        else $error("stray perr");
    chk_master_gate: assert property (master_allowed |-> master_want && !bus_disconnected)
        else $error("master gate");
    chk_end_burst: assert property (master_end_burst |-> gnt_n)
        else $error("early end");
    chk_int_pin: assert property ((inta_n_oe == irq_request) && (inta_n_out == 1'b0))
        else $error("int pin");

    cover property (cfg_claim ##1 cfg_ack);
    cover property (target_abort);
    cover property (master_end_burst);
endmodule : pcicf_header_chk

bind pcicf_header pcicf_header_chk i_chk (.clk, .reset, .cfg_req, .cfg_idsel, .cfg_ad,
    .cfg_claim, .cfg_ack, .mem_cycle, .mem_addr, .mem_hit, .mem_word, .addr_parity_err,
    .data_parity_err, .target_abort, .devsel_medium, .fast_b2b_accept, .master_want, .gnt_n,
    .master_read_parity_err, .master_allowed, .master_end_burst, .perr_n_oe, .serr_n_oe,
    .irq_request, .inta_n_out, .inta_n_oe, .bus_disconnected);

// ---- pcicf_host_model.sv ----
// Host bridge model issuing configuration cycles.
module pcicf_host_model
(
    // Clock
    input logic clk,
    // Request
    output logic cfg_req,
    output logic cfg_idsel,
    output logic [10:0] cfg_ad,
    output logic cfg_write,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // Answer
    input logic cfg_claim,
    input logic cfg_ack,
    input logic [31:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {cfg_req, cfg_idsel, cfg_write, cfg_be} = 7'h00;
        {cfg_ad, cfg_wdata} = '1;
    end

    // Released address and data lines show the inverse of their last value; the controls go low.
    task automatic access(input logic wr, input logic sel, input logic [10:0] ad,
        input logic [3:0] be, input logic [31:0] wd,
        output logic claim, output logic ack, output logic [31:0] rd);
        @(negedge clk);
        {cfg_req, cfg_idsel, cfg_ad} = {1'b1, sel, ad};
        {cfg_write, cfg_be, cfg_wdata} = {wr, be, wd};
        #1 claim = cfg_claim;
        @(negedge clk);
        ack = cfg_ack;
        rd = cfg_rdata;
        {cfg_req, cfg_idsel, cfg_write, cfg_be} = 7'h00;
        {cfg_ad, cfg_wdata} = {~ad, ~wd};
    endtask : access
endmodule : pcicf_host_model

// ---- tb.sv ----
// Self-checking bench for the configuration header bank.
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb
    import pcicf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Identity values are arbitrary.
    localparam logic [15:0] VEN = 16'h2468;
    localparam logic [15:0] DEV = 16'h1357;
    localparam logic [7:0] REV = 8'h03;
    localparam logic [15:0] BVEN = 16'h4321;
    localparam logic [15:0] BDEV = 16'h8765;
    logic clk = 1'b0, reset = 1'b1;
    logic cfg_req, cfg_idsel, cfg_write, cfg_claim, cfg_ack;
    logic [10:0] cfg_ad;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic mem_cycle = 0, mem_hit, addr_pe = 0, data_pe = 0, t_abort, devsel, fb2b;
    logic [31:0] mem_addr = 0;
    logic [MEM_WINDOW_BITS-3:0] mem_word;
    logic want = 0, burst = 0, gnt_n = 1, m_abort = 0, t_abort_in = 0, rd_pe = 0, wr_pe = 0;
    logic allowed, end_burst, perr_out, perr_oe, serr_out, serr_oe, irq = 0, inta_out, inta_oe;
    logic disc;
    logic [7:0] int_line;
    int bad_count = 0, n_checks = 0, cyc = 0;

    always #20 clk = ~clk;

    pcicf_host_model i_host (.clk, .cfg_req, .cfg_idsel, .cfg_ad, .cfg_write, .cfg_be,
        .cfg_wdata, .cfg_claim, .cfg_ack, .cfg_rdata);
    pcicf_header #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV), .REVISION_CODE(REV),
        .BOARD_VENDOR_CODE(BVEN), .BOARD_CODE(BDEV)) i_dut (.clk, .reset, .cfg_req, .cfg_idsel,
        .cfg_ad, .cfg_write, .cfg_be, .cfg_wdata, .cfg_claim, .cfg_ack, .cfg_rdata, .mem_cycle,
        .mem_addr, .mem_hit, .mem_word, .addr_parity_err(addr_pe), .data_parity_err(data_pe),
        .tgt_write_data_parity_err(1'b0), .target_abort(t_abort), .devsel_medium(devsel),
        .fast_b2b_accept(fb2b), .master_want(want), .burst_active(burst), .gnt_n,
        .master_abort_seen(m_abort), .target_abort_seen(t_abort_in),
        .master_read_parity_err(rd_pe), .master_write_perr_seen(wr_pe),
        .master_allowed(allowed), .master_end_burst(end_burst), .perr_n_out(perr_out),
        .perr_n_oe(perr_oe), .serr_n_out(serr_out), .serr_n_oe(serr_oe),
        .irq_request(irq), .inta_n_out(inta_out), .inta_n_oe(inta_oe),
        .bus_disconnected(disc), .int_line);

    task automatic cfg(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
        input logic [31:0] wd);
        logic c, a;
        i_host.access(wr, 1'b1, {FUNCTION_ONE, ofs}, be, wd, c, a, rd);
        `CHK("claim and ack", 2'b11, {c, a})
    endtask : cfg

    task automatic t_regs();
        logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h3c, 8'h14};
        logic [31:0] rst [8] = '{{DEV, VEN}, 32'h02800000, {CLASS_CODE, REV}, 32'h00800000,
            32'h00000008, {BDEV, BVEN}, 32'hff040100, 32'h0};
        logic [31:0] ones [8] = '{{DEV, VEN}, 32'h02800146, {CLASS_CODE, REV}, 32'h0080ff00,
            32'hfffff008, {BDEV, BVEN}, 32'hff0401ff, 32'h0};
        for (int i = 0; i < 8; i++)
        begin
            cfg(1'b0, ofs[i], 4'hf, 32'h0);
            `CHK("reset", rst[i], rd)
        end
        for (int i = 0; i < 8; i++)
        begin
            cfg(1'b1, ofs[i], 4'hf, 32'hffffffff);
            cfg(1'b0, ofs[i], 4'hf, 32'h0);
            `CHK("written", ones[i], rd)
        end
        `CHK("int line", 8'hff, int_line)
        cfg(1'b1, 8'h3c, 4'h2, 32'h0);
        cfg(1'b0, 8'h3c, 4'hf, 32'h0);
        `CHK("lane select", 32'hff0401ff, rd)
    endtask : t_regs

    task automatic t_select();
        logic c, a;
        i_host.access(1'b1, 1'b0, 11'h104, 4'hf, 32'h0, c, a, rd);
        `CHK("no idsel", 2'b00, {c, a})
        i_host.access(1'b1, 1'b1, 11'h105, 4'hf, 32'h0, c, a, rd);
        `CHK("type one", 2'b00, {c, a})
        i_host.access(1'b1, 1'b1, 11'h004, 4'hf, 32'h0, c, a, rd);
        `CHK("func zero", 2'b00, {c, a})
        cfg(1'b0, 8'h04, 4'hf, 32'h0);
        `CHK("command kept", 32'h02800146, rd)
    endtask : t_select

    task automatic t_decode();
        cfg(1'b1, 8'h10, 4'hf, 32'habcde000);
        @(negedge clk);
        mem_cycle = 1'b1;
        mem_addr = 32'habcde123;
        want = 1'b1;
        #1 `CHK("hit", 5'b11110, {mem_hit, devsel, fb2b, allowed, disc})
        `CHK("word", 10'h048, mem_word)
        mem_addr = 32'habcdf000;
        #1 `CHK("outside", 1'b0, mem_hit)
        mem_addr = 32'habcde004;
        cfg(1'b1, 8'h04, 4'hf, 32'h0);
        `CHK("disconnected", 5'b00001, {mem_hit, devsel, fb2b, allowed, disc})
        cfg(1'b1, 8'h04, 4'hf, 32'h00000146);
    endtask : t_decode

    task automatic t_status();
        @(negedge clk);
        {addr_pe, data_pe, m_abort, t_abort_in, wr_pe} = 5'h1f;
        @(negedge clk);
        {addr_pe, data_pe, m_abort, t_abort_in, wr_pe} = 5'h00;
        `CHK("events", 3'b111, {t_abort, serr_oe, perr_oe})
        `CHK("pin levels", 2'b00, {serr_out, perr_out})
        cfg(1'b0, 8'h04, 4'hf, 32'h0);
        `CHK("status set", 32'hfb800146, rd)
        cfg(1'b1, 8'h04, 4'hf, 32'h80000146);
        cfg(1'b0, 8'h04, 4'hf, 32'h0);
        `CHK("one cleared", 32'h7b800146, rd)
        cfg(1'b1, 8'h04, 4'hf, 32'hffff0002);
        @(negedge clk);
        {addr_pe, rd_pe} = 2'b11;
        @(negedge clk);
        {addr_pe, rd_pe} = 2'b00;
        `CHK("gated", 3'b100, {t_abort, serr_oe, perr_oe})
        cfg(1'b0, 8'h04, 4'hf, 32'h0);
        `CHK("status gated", 32'h8a800002, rd)
        cfg(1'b1, 8'h04, 4'hf, 32'hffff0146);
        mem_cycle = 1'b0;
    endtask : t_status

    task automatic t_latency();
        int n;
        cfg(1'b1, 8'h0c, 4'h2, 32'hffff03ff);
        cfg(1'b0, 8'h0c, 4'hf, 32'h0);
        `CHK("latency lane", 32'h00800300, rd)
        @(negedge clk);
        burst = 1'b1;
        irq = 1'b1;
        for (n = 0; n < 20 && end_burst !== 1'b1; n++)
            @(negedge clk);
        `CHK("expiry", 5, n)
        `CHK("int pin", 2'b10, {inta_oe, inta_out})
        gnt_n = 1'b0;
        #1 `CHK("grant held", 1'b0, end_burst)
        @(negedge clk);
        {burst, gnt_n, irq} = 3'b010;
    endtask : t_latency

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cyc++;
        if (cyc >= 5000)
        begin
            bad_count++;
            finish_test();
        end
    end

    initial
    begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        t_regs();
        t_select();
        t_decode();
        t_status();
        t_latency();
        finish_test();
    end
endmodule : tb
